// ===== design/sspc_pkg.sv
`default_nettype none
package sspc_pkg;
    // register byte addresses
    localparam logic [11:0] SSPC_MODE_OFF = 12'h000;
    localparam logic [11:0] SSPC_CFG_OFF = 12'h004;
    localparam logic [11:0] SSPC_STAT_OFF = 12'h008;
    // power mode codes
    localparam logic [7:0] SSPC_SLEEP_CODE = 8'h0f;
    localparam logic [7:0] SSPC_STOP_CODE = 8'h5a;
    localparam logic [7:0] SSPC_MODE_RST = 8'h00;
    // config field positions
    localparam int SSPC_CFG_PRESC_LSB = 0;
    localparam int SSPC_CFG_RCWD_BIT = 4;
    localparam int SSPC_CFG_EC_BIT = 5;
    localparam int SSPC_CFG_SEXT_BIT = 6;
    localparam int SSPC_CFG_IFLAG_BIT = 7;
    localparam logic [7:0] SSPC_CFG_RST = 8'h00;
    // interval timer
    localparam logic [7:0] SSPC_BIT_OVF = 8'hff;
    localparam logic [7:0] SSPC_BIT_ZERO = 8'h00;
    localparam logic [7:0] SSPC_PRESC_ZERO = 8'h00;

    typedef enum logic [1:0] {
        SSPC_RUN = 2'b00,
        SSPC_SLEEP = 2'b01,
        SSPC_STOP = 2'b10,
        SSPC_WAKE = 2'b11
    } sspc_state_t;

    // per-block clock gates
    typedef struct packed {
        logic cpu_run;
        logic osc_run;
        logic sys_clk;
        logic periph_clk;
        logic wdt_run;
        logic tmr_run;
        logic sio_run;
        logic buz_adc_run;
        logic bit_run;
    } sspc_gates_t;

    // wake events from the surrounding device
    typedef struct packed {
        logic irq_any;
        logic ext_irq;
        logic ec_event;
        logic wdt_event;
        logic sio_event;
    } sspc_wake_t;
endpackage
`default_nettype wire

// ===== design/sspc_top.sv
// Function
// - sleep code write halts CPU immediately
// - stop only on STOP with armed code
// - sleep keeps oscillator, peripheral clock and timers running
// - sleep ends on reset or any interrupt
// - interrupt wake keeps config, clears mode code when wake ends; reset clears
// - I-flag set vectors, clear resumes next
// - wake restarts interval timer, wait overflow
// - stop freezes oscillator, system, peripheral clocks
// - PC held at instruction after STOP
// - watchdog stopped except RC mode stop
// - timers run in sleep; stop only event counters
// - serial external clock only; buzzer, ADC off
// - stop ends on listed wake sources
// - interval timer halted, prescaler kept in stop
// - accepting maskable interrupt clears I-flag
`default_nettype none
module sspc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_instr,
    input wire logic int_accept,
    input wire sspc_pkg::sspc_wake_t wake_in,
    input wire logic [15:0] pc_next,
    output sspc_pkg::sspc_gates_t gates,
    output logic irq_vector,
    output logic resume_next,
    output logic pc_hold,
    output logic [15:0] pc_held,
    output logic [1:0] mode_state
);
    import sspc_pkg::*;

    sspc_state_t state_reg;
    logic [7:0] mode_reg;
    logic [7:0] cfg_reg;
    logic [7:0] bit_reg;
    logic [7:0] presc_reg;
    logic [4:0] wake_s1_reg;
    logic [4:0] wake_s2_reg;
    sspc_wake_t wk;
    logic wr_en;
    logic mode_wr;
    logic cfg_wr;
    logic sleep_go;
    logic stop_go;
    logic wake_sleep;
    logic wake_stop;
    logic presc_tick;
    logic iflag_on_wake;
    logic [7:0] presc_lim;

    // wake events come from other logic and pins; two-flop sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_s1_reg <= 5'h00;
            wake_s2_reg <= 5'h00;
        end else begin
            wake_s1_reg <= wake_in;
            wake_s2_reg <= wake_s1_reg;
        end
    end
    assign wk = sspc_wake_t'(wake_s2_reg);

    // apb decode: zero-wait, full byte lane 0 required for the mode code
    assign wr_en = psel && penable && pwrite;
    assign mode_wr = wr_en && (paddr == SSPC_MODE_OFF) && pstrb[0];
    assign cfg_wr = wr_en && (paddr == SSPC_CFG_OFF) && pstrb[0];
    assign sleep_go = (state_reg == SSPC_RUN) && mode_wr && (pwdata[7:0] == SSPC_SLEEP_CODE);
    assign stop_go = (state_reg == SSPC_RUN) && stop_instr && (mode_reg == SSPC_STOP_CODE);
    assign wake_sleep = wk.irq_any;
    assign wake_stop = wk.ext_irq || (wk.ec_event && cfg_reg[SSPC_CFG_EC_BIT])
        || (wk.wdt_event && cfg_reg[SSPC_CFG_RCWD_BIT])
        || (wk.sio_event && cfg_reg[SSPC_CFG_SEXT_BIT]);
    assign presc_lim = {4'h0, cfg_reg[SSPC_CFG_PRESC_LSB +: 4]};
    assign presc_tick = (presc_reg >= presc_lim);
    assign iflag_on_wake = cfg_reg[SSPC_CFG_IFLAG_BIT];

    // mode register; reset clears, end of wake period clears it
    // reset clears, wake end clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= SSPC_MODE_RST;
        end else if (mode_wr) begin
            // any value stored, only codes act
            mode_reg <= pwdata[7:0];
        end else if (state_reg == SSPC_WAKE && bit_reg == SSPC_BIT_OVF && presc_tick) begin
            mode_reg <= SSPC_MODE_RST; // disarm so next write must re-arm
        end
    end

    // config register; I-flag cleared by hardware on accept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= SSPC_CFG_RST;
        end else if (int_accept && state_reg == SSPC_RUN) begin
            // accept clears I-flag, wins over a write
            cfg_reg <= cfg_reg & ~(8'h01 << SSPC_CFG_IFLAG_BIT);
        end else if (cfg_wr) begin
            cfg_reg <= pwdata[7:0];
        end
    end

    // power state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SSPC_RUN;
        end else begin
            case (state_reg)
                SSPC_RUN: begin
                    if (sleep_go) begin
                        state_reg <= SSPC_SLEEP;
                    end else if (stop_go) begin
                        state_reg <= SSPC_STOP;
                    end
                end
                SSPC_SLEEP: begin
                    if (wake_sleep) begin
                        state_reg <= SSPC_WAKE;
                    end
                end
                SSPC_STOP: begin
                    if (wake_stop) begin
                        state_reg <= SSPC_WAKE;
                    end
                end
                SSPC_WAKE: begin
                    if (bit_reg == SSPC_BIT_OVF && presc_tick) begin
                        state_reg <= SSPC_RUN;
                    end
                end
                default: state_reg <= SSPC_RUN;
            endcase
        end
    end

    // prescaler: kept frozen during stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= SSPC_PRESC_ZERO;
        end else if (state_reg != SSPC_STOP) begin
            presc_reg <= presc_tick ? SSPC_PRESC_ZERO : presc_reg + 8'h01;
        end
    end

    // interval timer: cleared on wake entry, halted in stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_reg <= SSPC_BIT_ZERO;
        end else if ((state_reg == SSPC_SLEEP && wake_sleep)
                || (state_reg == SSPC_STOP && wake_stop)) begin
            bit_reg <= SSPC_BIT_ZERO;
        end else if (state_reg != SSPC_STOP && presc_tick) begin
            bit_reg <= bit_reg + 8'h01;
        end
    end

    // clock gates per state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gates <= '1;
        end else begin
            gates.cpu_run <= (state_reg == SSPC_RUN) && !sleep_go && !stop_go;
            gates.osc_run <= !(state_reg == SSPC_STOP || stop_go);
            gates.sys_clk <= !(state_reg == SSPC_STOP || stop_go);
            gates.periph_clk <= !(state_reg == SSPC_STOP || stop_go);
            gates.bit_run <= !(state_reg == SSPC_STOP || stop_go);
            gates.wdt_run <= (state_reg == SSPC_RUN && !sleep_go && !stop_go)
                || state_reg == SSPC_WAKE
                || ((state_reg == SSPC_STOP || stop_go) && cfg_reg[SSPC_CFG_RCWD_BIT]);
            gates.tmr_run <= !(state_reg == SSPC_STOP || stop_go) || cfg_reg[SSPC_CFG_EC_BIT];
            // serial ext clock only, buzzer and adc off
            gates.sio_run <= (state_reg == SSPC_RUN || state_reg == SSPC_WAKE)
                ? !sleep_go && !stop_go : cfg_reg[SSPC_CFG_SEXT_BIT];
            gates.buz_adc_run <= (state_reg == SSPC_RUN && !sleep_go && !stop_go)
                || state_reg == SSPC_WAKE;
        end
    end

    // wake outcome and program counter hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_vector <= 1'b0;
            resume_next <= 1'b0;
            pc_hold <= 1'b0;
            pc_held <= 16'h0000;
        end else begin
            irq_vector <= 1'b0;
            resume_next <= 1'b0;
            if (state_reg == SSPC_WAKE && bit_reg == SSPC_BIT_OVF && presc_tick) begin
                irq_vector <= iflag_on_wake;
                resume_next <= !iflag_on_wake;
            end
            if (stop_go || sleep_go) begin
                pc_held <= pc_next;
            end
            pc_hold <= (state_reg != SSPC_RUN) || stop_go || sleep_go;
        end
    end

    // apb read path, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            mode_state <= 2'b00;
        end else begin
            mode_state <= state_reg;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    SSPC_MODE_OFF: prdata <= {24'h000000, mode_reg};
                    SSPC_CFG_OFF: prdata <= {24'h000000, cfg_reg};
                    SSPC_STAT_OFF: prdata <= {22'h0, state_reg, bit_reg};
                    default: begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // pready high during access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    mode_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SSPC_SLEEP && !mode_wr) |=> $stable(mode_reg))
        else $error("mode register changed in sleep");
    stop_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SSPC_RUN && stop_instr && mode_reg != SSPC_STOP_CODE && !sleep_go)
        |=> state_reg == SSPC_RUN)
        else $error("stop entered without arming");
    sleep_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_go |=> state_reg == SSPC_SLEEP ##1 !gates.cpu_run)
        else $error("sleep not entered at once");
    stop_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SSPC_STOP |=> !gates.osc_run && !gates.periph_clk)
        else $error("clocks run in stop");
    bit_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SSPC_STOP && !wake_stop) |=> $stable(bit_reg) && $stable(presc_reg))
        else $error("timer moved in stop");
    wake_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SSPC_SLEEP && wake_sleep) |=> state_reg == SSPC_WAKE && bit_reg == 8'h00)
        else $error("timer not restarted on wake");
    wdt_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SSPC_SLEEP |=> !gates.wdt_run)
        else $error("watchdog runs in sleep");
    sleep_per_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SSPC_SLEEP |=> gates.osc_run && gates.tmr_run && gates.bit_run)
        else $error("peripheral stopped in sleep");
    wake_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(irq_vector && resume_next))
        else $error("vector and resume together");
    iflag_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (int_accept && state_reg == SSPC_RUN) |=> !cfg_reg[SSPC_CFG_IFLAG_BIT])
        else $error("I-flag not cleared");
    sleep_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == SSPC_SLEEP ##1 state_reg == SSPC_WAKE);
    stop_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == SSPC_STOP ##1 state_reg == SSPC_WAKE);
    vec_cov_c: cover property (@(posedge pclk) disable iff (!presetn) irq_vector);
endmodule
`default_nettype wire

// ===== sim/sspc_cpu_model.sv
`default_nettype none
module sspc_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stop_go,
    input wire logic hold,
    input wire logic irq_vector,
    input wire logic resume_next,
    input wire logic [1:0] mode_state,
    output logic stop_instr,
    output logic int_accept,
    output logic [15:0] pc_next,
    output int n_vec,
    output int n_res
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pc_reg;
    // next fetch is the first padding no-op
    assign pc_next = pc_reg + 16'h0001;
    // core fetches only while running and not busy with an entry instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= 16'h0100;
        end else if (mode_state == 2'b00 && !hold && !stop_go) begin
            pc_reg <= pc_reg + 16'h0001;
        end
    end
    // stop instruction issued on request, one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_instr <= 1'b0;
        end else begin
            stop_instr <= stop_go;
        end
    end
    // vectoring is taken as an accepted interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_accept <= 1'b0;
            n_vec <= 0;
            n_res <= 0;
        end else begin
            int_accept <= irq_vector;
            n_vec <= n_vec + (irq_vector ? 1 : 0);
            n_res <= n_res + (resume_next ? 1 : 0);
        end
    end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sspc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sspc_wake_t wake_in = '0;
    sspc_gates_t gates;
    logic irq_vector, resume_next, pc_hold, stop_instr, int_accept;
    logic stop_go = 1'b0;
    logic hold = 1'b0;
    logic [15:0] pc_held, pc_next;
    logic [1:0] mode_state;
    int n_fail = 0;
    int tests_run = 0;
    int n_vec, n_res;
    // expected wake outcome per entry: 1 vectored, 0 resumed
    int exp_q[$];
    logic [7:0] mbits [6] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h10, 8'h40};
    logic [4:0] src [6] = '{5'h10, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};

    always #25 pclk = ~pclk;

    sspc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_instr(stop_instr), .int_accept(int_accept),
        .wake_in(wake_in), .pc_next(pc_next), .gates(gates), .irq_vector(irq_vector),
        .resume_next(resume_next), .pc_hold(pc_hold), .pc_held(pc_held),
        .mode_state(mode_state));
    sspc_cpu_model cpu (.pclk(pclk), .presetn(presetn), .stop_go(stop_go), .hold(hold),
        .irq_vector(irq_vector), .resume_next(resume_next), .mode_state(mode_state),
        .stop_instr(stop_instr), .int_accept(int_accept), .pc_next(pc_next),
        .n_vec(n_vec), .n_res(n_res));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // whole-word transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            chk(0, 1, "no pready");
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_state(input logic [1:0] s);
        int i;
        for (i = 0; i < 64 && mode_state !== s; i++) @(posedge pclk);
        if (mode_state !== s) begin
            chk(0, 1, "state wait");
            conclude();
        end
    endtask

    // expected clock gating in sleep (slp=1) or stop (slp=0)
    function automatic logic [8:0] exp_gates(input logic slp, input logic [7:0] cf);
        sspc_gates_t g;
        g = '0;
        g.osc_run = slp;
        g.sys_clk = slp;
        g.periph_clk = slp;
        g.bit_run = slp;
        g.tmr_run = slp | cf[SSPC_CFG_EC_BIT];
        g.wdt_run = ~slp & cf[SSPC_CFG_RCWD_BIT];
        g.sio_run = cf[SSPC_CFG_SEXT_BIT];
        return g;
    endfunction

    initial begin
        logic [31:0] rd;
        logic er;
        logic [7:0] cfg, code;
        int c, p, n, v0, r0;
        void'($urandom(32'h2bd4));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and an unmapped read
        apb(1'b0, SSPC_MODE_OFF, 32'h0, rd, er);
        chk(rd, {24'h0, SSPC_MODE_RST}, "mode reset");
        apb(1'b0, SSPC_CFG_OFF, 32'h0, rd, er);
        chk(rd, {24'h0, SSPC_CFG_RST}, "cfg reset");
        chk(gates, 32'h1ff, "gates reset");
        apb(1'b0, 12'h0fc, 32'h0, rd, er);
        chk(er, 1, "unmapped read");
        $display("test reset done");
        // a write without byte lane 0 must not act
        pstrb <= 4'h0;
        apb(1'b1, SSPC_MODE_OFF, {24'h0, SSPC_SLEEP_CODE}, rd, er);
        pstrb <= 4'hf;
        repeat (3) @(posedge pclk);
        chk(mode_state, 0, "lane write");
        for (c = 0; c < 4; c++) begin
            code = 8'($urandom);
            if (code == SSPC_SLEEP_CODE || code == SSPC_STOP_CODE) code = code ^ 8'h01;
            // byte code written as a whole word
            apb(1'b1, SSPC_MODE_OFF, {24'h0, code}, rd, er);
            stop_go <= 1'b1;
            @(posedge pclk);
            stop_go <= 1'b0;
            repeat (4) @(posedge pclk);
            chk(mode_state, 0, "other code");
        end
        $display("test other codes done");
        for (c = 0; c < 6; c++) begin
            p = $urandom % 3;
            cfg = 8'(p) | mbits[c] | ((c % 2 == 0) ? 8'h80 : 8'h00);
            apb(1'b1, SSPC_CFG_OFF, {24'h0, cfg}, rd, er);
            exp_q.push_back(cfg[7] ? 1 : 0);
            hold <= 1'b1;
            if (c < 2) begin
                apb(1'b1, SSPC_MODE_OFF, {24'h0, SSPC_SLEEP_CODE}, rd, er);
            end else begin
                apb(1'b1, SSPC_MODE_OFF, {24'h0, SSPC_STOP_CODE}, rd, er);
                stop_go <= 1'b1;
                @(posedge pclk);
                stop_go <= 1'b0;
            end
            wait_state(c < 2 ? 2'b01 : 2'b10);
            repeat (2) @(posedge pclk);
            chk(gates, exp_gates(c < 2, cfg), "gates");
            chk(pc_hold, 1, "pc hold");
            chk(pc_held, pc_next, "pc held");
            if (c >= 2) begin
                wake_in <= 5'h10;
                repeat (6) @(posedge pclk);
                chk(mode_state, 2, "stop kept");
                wake_in <= '0;
            end
            v0 = n_vec;
            r0 = n_res;
            @(posedge pclk);
            wake_in <= src[c];
            wait_state(2'b11);
            wake_in <= '0; // wake source released after wake
            for (n = 1; n < 5000 && mode_state === 2'b11; n++) @(posedge pclk);
            if (n == 5000) begin
                chk(0, 1, "wake timeout");
                conclude();
            end
            chk(n > 256 * (p + 1) - 4 && n < 256 * (p + 1) + 4, 1, "wake length");
            repeat (3) @(posedge pclk);
            chk(n_vec - v0, exp_q[0], "vectored");
            chk(n_res - r0, 1 - exp_q.pop_front(), "resumed");
            chk(pc_hold, 0, "pc released");
            chk(gates, 32'h1ff, "gates run");
            apb(1'b0, SSPC_CFG_OFF, 32'h0, rd, er);
            chk(rd, {24'h0, cfg & 8'h7f}, "cfg kept");
            apb(1'b0, SSPC_STAT_OFF, 32'h0, rd, er);
            chk(rd[31:8], 24'h0, "stat run");
            hold <= 1'b0;
            $display("test low power case %0d done", c);
        end
        apb(1'b1, SSPC_CFG_OFF, 32'h85, rd, er);
        apb(1'b1, SSPC_MODE_OFF, {24'h0, SSPC_SLEEP_CODE}, rd, er);
        wait_state(2'b01);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(mode_state, 0, "reset wake");
        apb(1'b0, SSPC_CFG_OFF, 32'h0, rd, er);
        chk(rd, {24'h0, SSPC_CFG_RST}, "cfg after reset");
        $display("test reset wake done");
        conclude();
    end
endmodule
`default_nettype wire
